// ===== asc_regs_map.vh
// Constants for the setup and configuration register bank.
// Assumes inclusion by the bank and its buffer RAM timer only.
`ifndef ASC_REGS_MAP_VH
`define ASC_REGS_MAP_VH
// Port offsets inside a window
`define ASC_OFS_CFG_LO      4'h0
`define ASC_OFS_CFG_HI      4'h2
`define ASC_OFS_NVM_CMD     4'hA
`define ASC_OFS_NVM_DATA    4'hC
`define ASC_OFS_COMMAND     4'hE
// Windows
`define ASC_WIN_SETUP       3'h0
`define ASC_WIN_CONFIG      3'h3
// Command word layout and the window-select code
`define ASC_CMD_CODE_HI     15
`define ASC_CMD_CODE_LO     11
`define ASC_CMD_SEL_WINDOW  5'h01
// Nonvolatile command register layout
`define ASC_NVM_BUSY_BIT    15
`define ASC_NVM_TEST_BIT    14
`define ASC_NVM_OP_READ     2'h2
// Nonvolatile word addresses read at startup
`define ASC_NVM_W_PRODUCT   6'h03
`define ASC_NVM_W_ADDR_CFG  6'h08
`define ASC_NVM_W_RES_CFG   6'h09
`define ASC_NVM_W_CFG_LO    6'h12
`define ASC_NVM_W_CFG_HI    6'h13
// Writable bits of each configuration half
`define ASC_CFG_LO_MASK     16'h0037
`define ASC_CFG_HI_MASK     16'h000F
// Field positions in the 32-bit configuration word
`define ASC_ACT_HI          19
`define ASC_ACT_LO          18
`define ASC_PART_HI         17
`define ASC_PART_LO         16
`define ASC_SPEED_HI        5
`define ASC_SPEED_LO        4
`define ASC_WIDTH_BIT       3
`define ASC_SIZE_HI         2
`define ASC_SIZE_LO         0
// Field codes
`define ASC_ACT_CONT_ONLY   2'h1
`define ASC_ACT_PNP_ONLY    2'h2
`define ASC_PART_3_5        2'h0
`define ASC_PART_1_3        2'h1
`define ASC_PART_1_1        2'h2
`define ASC_SPEED_TWO       2'h0
`define ASC_SPEED_ONE       2'h1
`define ASC_SIZE_8K         3'h0
`define ASC_SIZE_32K        3'h2
`define ASC_KUNITS_8K       6'h08
`define ASC_KUNITS_32K      6'h20
// Test mode, normal mode and identification values
`define ASC_TEST_IO_BASE    16'h0200
`define ASC_ID_LEN_TEST     8'h08
`define ASC_ID_LEN_FULL     8'hFF
`define ASC_ID_FIRST        8'hFF
`define ASC_ID_LAST         8'h69
`define ASC_BASE_FIXED      6'h20
// Buffer RAM clock: 200 MHz system clock, 20 MHz RAM clock
`define ASC_SYS_MHZ         200
`define ASC_RAM_MHZ         20
`define ASC_RAM_DIV         (`ASC_SYS_MHZ / `ASC_RAM_MHZ)
// Divider reload value, one less than the clock ratio above
`define ASC_RAM_DIV_LOAD    4'h9
`define ASC_ZERO16          16'h0000
`endif

// ===== asc_ram_timer.v
// Buffer RAM access timer: counts access length in 20 MHz ticks.
// Assumes a 200 MHz clock and one request pulse at a time, taken only while idle.
`timescale 1ns/1ps
`include "asc_regs_map.vh"
module asc_ram_timer (
	input  wire       ref_clk_in,   // System clock
	input  wire       rst_n_in,     // Synchronous reset, active low
	input  wire       start_in,     // Start one access
	input  wire [1:0] ticks_in,     // Access length in RAM clocks
	output reg        done_out      // One-cycle end of access
);
	////////////////////////////////////////////////////////////
	reg [3:0] div;                  // Divider to the RAM rate
	reg [1:0] left;                 // RAM clocks still to run
	reg       busy;                 // Access in progress
	wire      tick = (div == 4'h0); // One-cycle RAM clock enable

	// Free-running divider makes the 20 MHz enable
	always @(posedge ref_clk_in) begin
		if (!rst_n_in || div == 4'h0) begin
			div <= `ASC_RAM_DIV_LOAD;
		end else begin
			div <= div - 4'h1;
		end
	end

	// Count RAM clocks of the current access
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			busy     <= 1'b0;
			left     <= 2'h0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (!busy && start_in) begin
				busy <= 1'b1;
				left <= ticks_in;
			end else if (busy && tick) begin
				if (left == 2'h1) begin
					busy     <= 1'b0;
					done_out <= 1'b1;
				end
				left <= left - 2'h1;
			end
		end
	end
endmodule // asc_ram_timer

// ===== asc_setup_regs.v
// Setup-window and configuration-window register bank of the adapter.
// Assumes 16-bit host I/O port accesses, one strobe a cycle, and an
// external serial engine for the nonvolatile memory.
`timescale 1ns/1ps
`include "asc_regs_map.vh"
module asc_setup_regs (
	input  wire        ref_clk_in,        // 200 MHz clock
	input  wire        rst_n_in,          // Synchronous reset, active low
	input  wire [3:0]  io_addr_in,        // Port offset within window
	input  wire        io_wr_in,          // Write strobe
	input  wire        io_rd_in,          // Read strobe
	input  wire [15:0] io_wdata_in,       // Write data
	output reg  [15:0] io_rdata_out,      // Read data
	output reg  [2:0]  window_out,        // Selected window
	output reg  [15:0] cmd_out,           // Command passed on
	output reg         cmd_strobe_out,    // Command pulse
	input  wire        nvm_din_in,        // Memory data pin, strap
	input  wire        nvm_busy_in,       // Serial engine busy
	input  wire        nvm_rvalid_in,     // Fetched word pulse
	input  wire [15:0] nvm_rdata_in,      // Fetched word
	output reg  [7:0]  nvm_cmd_out,       // Opcode and address
	output reg         nvm_cmd_strobe_out,// Command pulse
	output wire [15:0] nvm_wdata_out,     // Word to store
	output reg  [15:0] product_id_out,    // Product identifier
	output reg  [15:0] addr_cfg_out,      // Address configuration
	output reg  [15:0] res_cfg_out,       // Resource configuration
	output reg         init_done_out,     // Startup load finished
	output wire        act_contention_out,// Contention allowed
	output wire        act_pnp_out,       // Plug-and-play allowed
	output reg  [5:0]  tx_kunits_out,     // Transmit share, K units
	output reg  [5:0]  rx_kunits_out,     // Receive share, K units
	output wire        cfg_illegal_out,   // Reserved code in use
	input  wire        ram_req_in,        // Buffer RAM access start
	output wire        ram_done_out,      // Buffer RAM access end
	output wire        boot_rom_en_out,   // Boot ROM enable
	input  wire        id_active_in,      // Activated by id sequence
	output wire        adapter_active_out,// Adapter answers I/O
	output wire [15:0] io_base_out,       // I/O base address
	output wire [7:0]  id_len_out,        // Identification length
	output wire [7:0]  id_first_out,      // First identification byte
	output wire [7:0]  id_last_out        // Last identification byte
);
	////////////////////////////////////////////////////////////
	// Startup states
	localparam [2:0] ST_ISSUE = 3'h0;     // Send next read
	localparam [2:0] ST_WAIT  = 3'h1;     // Wait for word
	localparam [2:0] ST_DONE  = 3'h2;     // Load finished
	localparam [2:0] ST_LAST  = 3'h4;     // Index of last word

	reg [2:0]  state;                     // Startup state
	reg [2:0]  idx;                       // Startup word index
	reg        test_mode_flag;            // Strap caught at reset
	reg        host_read;                 // Host read in flight
	reg [15:0] nvm_data_word;             // Data register
	reg [15:0] cfg_lo;                    // Configuration, low half
	reg [15:0] cfg_hi;                    // Configuration, high half
	reg [5:0]  init_word;                 // Word of this index
	wire       nvm_busy_flag;             // Busy seen by host
	wire [31:0] cfg;                      // Whole configuration
	wire       wr_w0;                     // Write in setup window
	wire       wr_w3;                     // Write in config window

	assign nvm_busy_flag = nvm_busy_in | host_read | nvm_cmd_strobe_out | (state != ST_DONE);
	assign cfg   = {cfg_hi, cfg_lo};
	assign wr_w0 = io_wr_in && (window_out == `ASC_WIN_SETUP);
	assign wr_w3 = io_wr_in && (window_out == `ASC_WIN_CONFIG);
	assign nvm_wdata_out = nvm_data_word;

	////////////////////////////////////////////////////////////
	// Word address for each startup step
	always @* begin
		case (idx)
			3'h0:    init_word = `ASC_NVM_W_PRODUCT;
			3'h1:    init_word = `ASC_NVM_W_ADDR_CFG;
			3'h2:    init_word = `ASC_NVM_W_RES_CFG;
			3'h3:    init_word = `ASC_NVM_W_CFG_LO;
			default: init_word = `ASC_NVM_W_CFG_HI;
		endcase
	end

	////////////////////////////////////////////////////////////
	// Test strap, caught while reset is held
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			test_mode_flag <= ~nvm_din_in;
		end
	end

	////////////////////////////////////////////////////////////
	// Startup load, memory commands and the loaded registers
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state              <= ST_ISSUE;
			idx                <= 3'h0;
			host_read          <= 1'b0;
			nvm_cmd_out        <= 8'h00;
			nvm_cmd_strobe_out <= 1'b0;
			nvm_data_word      <= `ASC_ZERO16;
			product_id_out     <= `ASC_ZERO16;
			addr_cfg_out       <= `ASC_ZERO16;
			res_cfg_out        <= `ASC_ZERO16;
			cfg_lo             <= `ASC_ZERO16;
			cfg_hi             <= `ASC_ZERO16;
			init_done_out      <= 1'b0;
		end else begin
			nvm_cmd_strobe_out <= 1'b0;
			case (state)
				ST_ISSUE: begin
					// Test mode leaves everything at zero
					if (test_mode_flag) begin
						state         <= ST_DONE;
						init_done_out <= 1'b1;
					end else if (!nvm_busy_in) begin
						nvm_cmd_out        <= {`ASC_NVM_OP_READ, init_word};
						nvm_cmd_strobe_out <= 1'b1;
						state              <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// Route the fetched word to its register
					if (nvm_rvalid_in) begin
						case (idx)
							3'h0:    product_id_out <= nvm_rdata_in;
							3'h1:    addr_cfg_out   <= nvm_rdata_in;
							3'h2:    res_cfg_out    <= nvm_rdata_in;
							3'h3:    cfg_lo <= nvm_rdata_in & `ASC_CFG_LO_MASK;
							default: cfg_hi <= nvm_rdata_in & `ASC_CFG_HI_MASK;
						endcase
						if (idx == ST_LAST) begin
							state         <= ST_DONE;
							init_done_out <= 1'b1;
						end else begin
							idx   <= idx + 3'h1;
							state <= ST_ISSUE;
						end
					end
				end
				ST_DONE: begin
					// Host command accepted only when not busy
					if (wr_w0 && io_addr_in == `ASC_OFS_NVM_CMD && !nvm_busy_flag) begin
						nvm_cmd_out        <= io_wdata_in[7:0];
						nvm_cmd_strobe_out <= 1'b1;
						host_read <= (io_wdata_in[7:6] == `ASC_NVM_OP_READ);
					end else if (host_read && nvm_rvalid_in) begin
						nvm_data_word <= nvm_rdata_in;
						host_read     <= 1'b0;
					end else if (wr_w0 && io_addr_in == `ASC_OFS_NVM_DATA
					             && !nvm_busy_flag) begin
						nvm_data_word <= io_wdata_in;
					end
					// Halves of the configuration written apart
					if (wr_w3 && io_addr_in == `ASC_OFS_CFG_LO) begin
						cfg_lo <= io_wdata_in & `ASC_CFG_LO_MASK;
					end
					if (wr_w3 && io_addr_in == `ASC_OFS_CFG_HI) begin
						cfg_hi <= io_wdata_in & `ASC_CFG_HI_MASK;
					end
				end
				default: begin
					state <= ST_ISSUE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// Command register: window select and command pass-on
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			window_out     <= `ASC_WIN_SETUP;
			cmd_out        <= `ASC_ZERO16;
			cmd_strobe_out <= 1'b0;
		end else begin
			cmd_strobe_out <= 1'b0;
			if (io_wr_in && io_addr_in == `ASC_OFS_COMMAND) begin
				if (io_wdata_in[`ASC_CMD_CODE_HI:`ASC_CMD_CODE_LO]
				    == `ASC_CMD_SEL_WINDOW) begin
					window_out <= io_wdata_in[2:0];
				end else if (window_out != `ASC_WIN_SETUP) begin
					// Other commands dropped in the setup window
					cmd_out        <= io_wdata_in;
					cmd_strobe_out <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Registered read data; unmapped offsets read zero
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			io_rdata_out <= `ASC_ZERO16;
		end else if (io_rd_in) begin
			io_rdata_out <= `ASC_ZERO16;
			if (io_addr_in == `ASC_OFS_COMMAND) begin
				io_rdata_out <= {13'h0000, window_out};
			end else if (window_out == `ASC_WIN_SETUP) begin
				case (io_addr_in)
					`ASC_OFS_NVM_CMD:  io_rdata_out <= {nvm_busy_flag,
					                    test_mode_flag, 6'h00, nvm_cmd_out};
					`ASC_OFS_NVM_DATA: io_rdata_out <= nvm_data_word;
					default:           io_rdata_out <= `ASC_ZERO16;
				endcase
			end else if (window_out == `ASC_WIN_CONFIG) begin
				case (io_addr_in)
					`ASC_OFS_CFG_LO: io_rdata_out <= cfg_lo;
					`ASC_OFS_CFG_HI: io_rdata_out <= cfg_hi;
					default:         io_rdata_out <= `ASC_ZERO16;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Activation select decode; 00b and 11b enable both
	assign act_contention_out =
		(cfg[`ASC_ACT_HI:`ASC_ACT_LO] != `ASC_ACT_PNP_ONLY);
	assign act_pnp_out =
		(cfg[`ASC_ACT_HI:`ASC_ACT_LO] != `ASC_ACT_CONT_ONLY);

	////////////////////////////////////////////////////////////
	// Buffer RAM partition by size and ratio
	reg [5:0] total;                      // Capacity in K units
	always @* begin
		total = (cfg[`ASC_SIZE_HI:`ASC_SIZE_LO] == `ASC_SIZE_32K)
		        ? `ASC_KUNITS_32K : `ASC_KUNITS_8K;
		case (cfg[`ASC_PART_HI:`ASC_PART_LO])
			`ASC_PART_3_5: tx_kunits_out = (total >> 3) * 6'h03;
			`ASC_PART_1_3: tx_kunits_out = total >> 2;
			default:       tx_kunits_out = total >> 1;
		endcase
		rx_kunits_out = total - tx_kunits_out;
	end

	// Reserved codes and illegal combinations flagged
	assign cfg_illegal_out =
		(cfg[`ASC_PART_HI:`ASC_PART_LO] == 2'h3) ||
		(cfg[`ASC_PART_HI] == 1'b0 &&
		 cfg[`ASC_SIZE_HI:`ASC_SIZE_LO] != `ASC_SIZE_8K) ||
		(cfg[`ASC_SPEED_HI] == 1'b1) ||
		(cfg[`ASC_SIZE_HI:`ASC_SIZE_LO] != `ASC_SIZE_8K &&
		 cfg[`ASC_SIZE_HI:`ASC_SIZE_LO] != `ASC_SIZE_32K);

	////////////////////////////////////////////////////////////
	// Buffer RAM access length; byte-wide only since width is zero
	wire [1:0] ram_ticks;                 // RAM clocks per access
	assign ram_ticks = (cfg[`ASC_SPEED_HI:`ASC_SPEED_LO] == `ASC_SPEED_ONE)
	                   ? 2'h1 : 2'h2;
	asc_ram_timer u_ram_timer (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (ram_req_in),
		.ticks_in   (ram_ticks),
		.done_out   (ram_done_out)
	);

	////////////////////////////////////////////////////////////
	// Test mode effects on boot ROM, base and identification
	assign boot_rom_en_out    = ~test_mode_flag;
	assign adapter_active_out = test_mode_flag | id_active_in;
	assign io_base_out = test_mode_flag ? `ASC_TEST_IO_BASE :
	                     {addr_cfg_out[5:0], `ASC_BASE_FIXED, 4'h0};
	assign id_len_out   = test_mode_flag ? `ASC_ID_LEN_TEST
	                                     : `ASC_ID_LEN_FULL;
	assign id_first_out = `ASC_ID_FIRST;
	assign id_last_out  = `ASC_ID_LAST;
endmodule // asc_setup_regs

// ===== asc_setup_monitor.sv
// Checker of the setup register bank, bound to its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module asc_setup_monitor (
	input logic        ref_clk_in,
	input logic        rst_n_in,
	input logic [3:0]  io_addr_in,
	input logic        io_wr_in,
	input logic        io_rd_in,
	input logic [15:0] io_wdata_in,
	input logic [15:0] io_rdata_out,
	input logic [2:0]  window_out,
	input logic        cmd_strobe_out,
	input logic        nvm_busy_in,
	input logic        nvm_cmd_strobe_out,
	input logic [15:0] product_id_out,
	input logic [15:0] addr_cfg_out,
	input logic [15:0] res_cfg_out,
	input logic        init_done_out,
	input logic        act_contention_out,
	input logic        act_pnp_out,
	input logic        boot_rom_en_out,
	input logic        adapter_active_out,
	input logic [15:0] io_base_out,
	input logic [7:0]  id_len_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!rst_n_in);
////////////////////////////////////////////////////////////////////////////////
// Decoded host accesses
wire       cw  = io_wr_in && io_addr_in == 4'hE;   // Command port write
wire       sel = io_wdata_in[15:11] == 5'h01;      // Window-select code
wire       w0  = window_out == 3'h0;               // Setup window open
wire       w3  = window_out == 3'h3;               // Configuration window open
wire [2:0] wn  = io_wdata_in[2:0];                 // Window asked for
wire [1:0] act = io_wdata_in[3:2];                 // Activation code written
wire       tst = !boot_rom_en_out;                 // Test strap seen
////////////////////////////////////////////////////////////////////////////////
// Command port
property p_win0_drop; cw && w0 && !sel |=> !cmd_strobe_out; endproperty
a_win0_drop: assert property (p_win0_drop) else $error("setup window passed a command");
property p_sel; cw && sel |=> window_out == $past(wn) && !cmd_strobe_out; endproperty
a_sel: assert property (p_sel) else $error("window select not taken");
// Configuration register
property p_act; io_wr_in && io_addr_in == 4'h2 && w3 |=>
	act_contention_out == ($past(act) != 2'h2) && act_pnp_out == ($past(act) != 2'h1);
endproperty
a_act: assert property (p_act) else $error("activation decode wrong");
property p_lo_rsv; io_rd_in && io_addr_in == 4'h0 && w3 |=> (io_rdata_out & 16'hFFC8) == 16'h0;
endproperty
a_lo_rsv: assert property (p_lo_rsv) else $error("low half reserved bits set");
property p_hi_rsv; io_rd_in && io_addr_in == 4'h2 && w3 |=> io_rdata_out[15:4] == 12'h000;
endproperty
a_hi_rsv: assert property (p_hi_rsv) else $error("high half reserved bits set");
// Memory commands
property p_busy; io_wr_in && io_addr_in == 4'hA && w0 && nvm_busy_in |=> !nvm_cmd_strobe_out;
endproperty
a_busy: assert property (p_busy) else $error("command sent while busy");
property p_b2b; io_wr_in && io_addr_in == 4'hA && w0 && nvm_cmd_strobe_out |=> !nvm_cmd_strobe_out;
endproperty
a_b2b: assert property (p_b2b) else $error("back-to-back command sent");
// Test mode
property p_test_out; tst |-> adapter_active_out && io_base_out == 16'h0200 && id_len_out == 8'h08;
endproperty
a_test_out: assert property (p_test_out) else $error("test mode outputs wrong");
property p_test_regs; tst |-> (product_id_out | addr_cfg_out | res_cfg_out) == 16'h0000;
endproperty
a_test_regs: assert property (p_test_regs) else $error("test mode registers loaded");
property p_test_init; $rose(rst_n_in) && tst |=> init_done_out && !nvm_cmd_strobe_out;
endproperty
a_test_init: assert property (p_test_init) else $error("test mode ran startup");
endmodule // asc_setup_monitor
bind asc_setup_regs asc_setup_monitor i_mon (.ref_clk_in, .rst_n_in, .io_addr_in, .io_wr_in,
	.io_rd_in, .io_wdata_in, .io_rdata_out, .window_out, .cmd_strobe_out, .nvm_busy_in,
	.nvm_cmd_strobe_out, .product_id_out, .addr_cfg_out, .res_cfg_out, .init_done_out,
	.act_contention_out, .act_pnp_out, .boot_rom_en_out, .adapter_active_out, .io_base_out,
	.id_len_out);

// ===== asc_nvm_model.sv
// Serial memory engine model facing the setup register bank.
// Assumes one command at a time, each strobed for one cycle.
`timescale 1ns/1ps
module asc_nvm_model (
	input  logic        ref_clk_in,    // System clock
	input  logic        rst_n_in,      // Synchronous reset, active low
	input  logic        slow_in,       // Long answer time
	input  logic [7:0]  cmd_in,        // Opcode and address
	input  logic        cmd_strobe_in, // Command pulse
	input  logic [15:0] wdata_in,      // Word to store
	output logic        busy_out,      // Engine busy
	output logic        rvalid_out,    // Fetched word pulse
	output logic [15:0] rdata_out      // Fetched word
);
logic [15:0] mem [0:63]; // Stored words
logic [15:0] last;       // Last fetched word
logic [6:0]  cnt;        // Cycles left in the command
logic [7:0]  op;         // Command being run
// Contents seen by the startup load
initial begin
	for (int i = 0; i < 64; i++)
		mem[i] = 16'h4C00 | 16'(i);
	mem[3] = 16'h1234;
	mem[8] = 16'h0005;
	mem[9] = 16'h3000;
	mem[18] = 16'hFFFF;
	mem[19] = 16'hFFF6;
end
// Command timing, fetch and store
always @(posedge ref_clk_in) begin
	rvalid_out <= 1'b0;
	if (!rst_n_in) begin
		busy_out <= 1'b0;
		cnt <= 7'h00;
	end else if (cmd_strobe_in) begin
		busy_out <= 1'b1;
		op <= cmd_in;
		cnt <= slow_in ? 7'h3C : 7'h03;
	end else if (busy_out && cnt != 7'h00) begin
		cnt <= cnt - 7'h01;
	end else if (busy_out) begin
		busy_out <= 1'b0;
		rvalid_out <= op[7:6] == 2'h2;
		if (op[7:6] == 2'h2)
			last <= mem[op[5:0]];
		if (op[7:6] == 2'h1)
			mem[op[5:0]] <= wdata_in;
	end
end
// Word lines do not hold the old value outside the pulse
assign rdata_out = rvalid_out ? last : ~last;
endmodule // asc_nvm_model

// ===== test_adapter_setup_config_regs.sv
// Self-checking bench of the setup register bank.
// Assumes the memory engine model and the bound checker.
`timescale 1ns/1ps
module test_adapter_setup_config_regs;
logic        ref_clk_in, rst_n_in, io_wr_in, io_rd_in, nvm_din_in, ram_req_in;
logic        id_active_in, slow, cmd_strobe_out, nvm_busy_in, nvm_rvalid_in;
logic        nvm_cmd_strobe_out, init_done_out, act_contention_out, act_pnp_out;
logic        cfg_illegal_out, ram_done_out, boot_rom_en_out, adapter_active_out;
logic [2:0]  window_out;
logic [3:0]  io_addr_in;
logic [5:0]  tx_kunits_out, rx_kunits_out;
logic [7:0]  nvm_cmd_out, id_len_out, id_first_out, id_last_out;
logic [15:0] io_wdata_in, io_rdata_out, cmd_out, nvm_wdata_out, nvm_rdata_in, d;
logic [15:0] product_id_out, addr_cfg_out, res_cfg_out, io_base_out;
int          fails = 0, comparisons = 0, ncmd = 0, nnvm = 0, n;
////////////////////////////////////////////////////////////////////////////////
asc_setup_regs i_dut (.ref_clk_in, .rst_n_in, .io_addr_in, .io_wr_in, .io_rd_in,
	.io_wdata_in, .io_rdata_out, .window_out, .cmd_out, .cmd_strobe_out, .nvm_din_in,
	.nvm_busy_in, .nvm_rvalid_in, .nvm_rdata_in, .nvm_cmd_out, .nvm_cmd_strobe_out,
	.nvm_wdata_out, .product_id_out, .addr_cfg_out, .res_cfg_out, .init_done_out,
	.act_contention_out, .act_pnp_out, .tx_kunits_out, .rx_kunits_out, .cfg_illegal_out,
	.ram_req_in, .ram_done_out, .boot_rom_en_out, .id_active_in, .adapter_active_out,
	.io_base_out, .id_len_out, .id_first_out, .id_last_out);
asc_nvm_model i_nvm (.ref_clk_in, .rst_n_in, .slow_in(slow), .cmd_in(nvm_cmd_out),
	.cmd_strobe_in(nvm_cmd_strobe_out), .wdata_in(nvm_wdata_out), .busy_out(nvm_busy_in),
	.rvalid_out(nvm_rvalid_in), .rdata_out(nvm_rdata_in));
////////////////////////////////////////////////////////////////////////////////
// 200 MHz clock
initial begin
	ref_clk_in = 1'b0;
	forever #2.5 ref_clk_in = ~ref_clk_in;
end
// Strobe counters
always @(posedge ref_clk_in) begin
	ncmd <= ncmd + int'(cmd_strobe_out);
	nnvm <= nnvm + int'(nvm_strobe_cnt());
end
function automatic bit nvm_strobe_cnt();
	return nvm_cmd_strobe_out === 1'b1;
endfunction
// Verdict and end of run
task test_done;
	$display("comparisons %0d, fails %0d", comparisons, fails);
	if (fails == 0 && comparisons > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
// Watchdog
initial begin
	#200000;
	fails++;
	$display("watchdog expired");
	test_done;
end
////////////////////////////////////////////////////////////////////////////////
task chk(input [31:0] got, input [31:0] exp);
	comparisons++;
	if (got !== exp) begin
		fails++;
		$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
	end
endtask
task tick;
	@(posedge ref_clk_in) #1;
endtask
// One register write, then an idle cycle
task wr(input [3:0] a, input [15:0] v);
	io_addr_in = a;
	io_wdata_in = v;
	io_wr_in = 1'b1;
	tick;
	io_wr_in = 1'b0;
	tick;
endtask
// One register read into d
task rq(input [3:0] a);
	io_addr_in = a;
	io_rd_in = 1'b1;
	tick;
	io_rd_in = 1'b0;
	d = io_rdata_out;
	tick;
endtask
task rd(input [3:0] a, input [15:0] e);
	rq(a);
	chk(d, e);
endtask
// Poll the memory busy flag until clear
task poll;
	d = 16'hFFFF;
	for (n = 0; n < 100 && d[15] !== 1'b0; n++)
		rq(4'hA);
	chk(n < 100, 1);
endtask
task rst(input din);
	rst_n_in = 1'b0;
	nvm_din_in = din;
	repeat (3) @(posedge ref_clk_in);
	#1 rst_n_in = 1'b1;
	n = nnvm;
endtask
// Size and partition, then shares and reserved flag
task pc(input [1:0] p, input [2:0] s, input [5:0] t, input [5:0] r, input il);
	wr(4'h0, {13'h0, s});
	wr(4'h2, {14'h0, p});
	chk(cfg_illegal_out, il);
	if (!il)
		chk({tx_kunits_out, rx_kunits_out}, {t, r});
	rd(4'h0, {13'h0, s});
endtask
// Buffer RAM access length in cycles
task rt(input [1:0] s, input int lo, input int hi, input il);
	wr(4'h0, {10'h0, s, 4'h0});
	chk(cfg_illegal_out, il);
	ram_req_in = 1'b1;
	tick;
	ram_req_in = 1'b0;
	for (n = 1; n < 40 && ram_done_out !== 1'b1; n++)
		tick;
	chk(n >= lo && n <= hi, 1);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	{io_wr_in, io_rd_in, ram_req_in, id_active_in, slow} = 5'h00;
	io_addr_in = 4'h0;
	io_wdata_in = 16'h0000;
	rst(1'b1);
	for (n = 0; n < 300 && init_done_out !== 1'b1; n++)
		tick;
	chk(n < 300, 1);
	chk({product_id_out, addr_cfg_out}, 32'h1234_0005);
	chk(res_cfg_out, 16'h3000);
	chk(io_base_out, 16'h1600);
	wr(4'hE, 16'h0803);
	rd(4'h0, 16'h0037);
	rd(4'h2, 16'h0006);
	chk({act_contention_out, act_pnp_out, tx_kunits_out, rx_kunits_out}, 14'h2104);
	id_active_in = 1'b1;
	tick;
	chk({boot_rom_en_out, adapter_active_out, id_len_out}, 10'h3FF);
	$display("test startup done");
	for (int i = 0; i < 4; i++) begin
		wr(4'h2, {12'h0, 2'(i), 2'h2});
		chk({act_contention_out, act_pnp_out}, i == 1 ? 2 : i == 2 ? 1 : 3);
	end
	pc(2'h0, 3'h0, 6'h03, 6'h05, 1'b0);
	pc(2'h1, 3'h0, 6'h02, 6'h06, 1'b0);
	pc(2'h2, 3'h0, 6'h04, 6'h04, 1'b0);
	pc(2'h2, 3'h2, 6'h10, 6'h10, 1'b0);
	pc(2'h0, 3'h2, 6'h00, 6'h00, 1'b1);
	pc(2'h3, 3'h0, 6'h00, 6'h00, 1'b1);
	pc(2'h2, 3'h1, 6'h00, 6'h00, 1'b1);
	wr(4'h0, 16'h000A);
	rd(4'h0, 16'h0002);
	rt(2'h1, 1, 13, 1'b0);
	rt(2'h2, 10, 23, 1'b1);
	rt(2'h3, 10, 23, 1'b1);
	rt(2'h0, 10, 23, 1'b0);
	$display("test configuration done");
	n = ncmd;
	wr(4'hE, 16'h1000);
	chk({8'(ncmd - n), cmd_out}, 24'h01_1000);
	wr(4'hE, 16'h0800);
	rd(4'hE, 16'h0000);
	wr(4'hE, 16'h1000);
	chk({8'(ncmd - n), 5'h00, window_out}, 16'h0100);
	$display("test command port done");
	slow = 1'b1;
	wr(4'hC, 16'h5A5A);
	wr(4'hA, 16'h0083);
	rd(4'hA, 16'h8083);
	wr(4'hA, 16'h0088);
	wr(4'hC, 16'hFFFF);
	chk({nvm_cmd_out, nvm_wdata_out}, 24'h83_5A5A);
	poll;
	rd(4'hC, 16'h1234);
	slow = 1'b0;
	wr(4'hC, 16'hBEEF);
	// Store command, then a read command on the very next edge
	io_addr_in = 4'hA;
	io_wdata_in = 16'h0045;
	io_wr_in = 1'b1;
	tick;
	io_wdata_in = 16'h0083;
	tick;
	io_wr_in = 1'b0;
	poll;
	chk(nvm_cmd_out, 8'h45);
	wr(4'hA, 16'h0085);
	poll;
	rd(4'hC, 16'hBEEF);
	wr(4'hA, 16'h0083);
	poll;
	rd(4'hC, 16'h1234);
	$display("test memory access done");
	id_active_in = 1'b0;
	rst(1'b0);
	tick;
	chk(init_done_out, 1);
	repeat (20) tick;
	chk(nnvm - n, 0);
	chk(product_id_out | addr_cfg_out | res_cfg_out, 0);
	chk({boot_rom_en_out, adapter_active_out, io_base_out}, 18'h1_0200);
	chk({id_len_out, id_first_out, id_last_out}, 24'h08FF69);
	rd(4'hA, 16'h4000);
	$display("test test mode done");
	test_done;
end
endmodule // test_adapter_setup_config_regs
